// ### rtl/clk_ctrl.sv
`timescale 1ns/1ps
module clk_ctrl
    import clk_ctrl_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              ext_osc_toggle,
    input  wire logic              pll_ref_toggle,
    input  wire logic              irq_pending,
    input  wire logic [WAKE_W-1:0] event_lines,
    output logic                   sys_clk_sel_ext,
    output logic                   external_crystal_osc_en,
    output logic                   internal_fast_rc_en,
    output logic                   pll_en,
    output logic                   cpu_clk_en,
    output logic                   ahb_clk_en,
    output logic                   apb_clk_en,
    output logic                   low_speed_keep_en,
    output logic                   irq
);

    logic [4:0]        ctrl_r;
    logic [7:0]        presc_r;
    logic [IRQ_W-1:0]  irq_stat_r;
    logic [IRQ_W-1:0]  irq_en_r;
    logic [WAKE_W-1:0] wake_en_r;
    clk_src_type       src_r;
    pwr_state_type     pwr_r;
    logic [PRESC_W-1:0] ahb_cnt_r;
    logic [PRESC_W-1:0] apb_cnt_r;
    logic              ext_fail;
    logic              pll_fail;
    logic              wr_en;
    logic              rd_en;
    logic              wake_evt;
    logic              addr_ok;
    logic [IRQ_W-1:0]  irq_set;
    logic [IRQ_W-1:0]  irq_clr;

    // =========================================================
    // APB decode: zero wait states, unmapped addresses error
    assign wr_en    = psel && penable && pwrite && pready;
    assign rd_en    = psel && !penable && !pwrite;
    assign wake_evt = |(event_lines & wake_en_r);
    assign addr_ok  = (paddr == CTRL_OFS) || (paddr == PRESC_OFS) || (paddr == STATE_OFS)
                   || (paddr == IRQ_STAT_OFS) || (paddr == IRQ_CLR_OFS)
                   || (paddr == IRQ_EN_OFS) || (paddr == WAKE_EN_OFS);

    // Ready and error registered in setup, standing through the access phase
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !addr_ok;
        end
    end

    // =========================================================
    // Oscillator monitors
    clk_edge_monitor u_ext_mon (
        .core_clk   (core_clk),
        .rst        (rst),
        .enable     (src_r == SRC_EXT && pwr_r != PWR_STOP),
        .osc_toggle (ext_osc_toggle),
        .failed     (ext_fail)
    );

    clk_edge_monitor u_pll_mon (
        .core_clk   (core_clk),
        .rst        (rst),
        .enable     (ctrl_r[CTRL_PLL_ON_BIT] && pwr_r != PWR_STOP),
        .osc_toggle (pll_ref_toggle),
        .failed     (pll_fail)
    );

    // =========================================================
    // Control register; failure drops the external selection
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctrl_r <= CTRL_RST;
        end else begin
            if (wr_en && paddr == CTRL_OFS) begin
                ctrl_r <= pwdata[4:0];
            end
            if (ext_fail) begin
                ctrl_r[CTRL_SEL_EXT_BIT] <= 1'b0;
            end
            if (pwr_r == PWR_SLEEP && (irq_pending || wake_evt)) begin
                ctrl_r[CTRL_SLEEP_BIT] <= 1'b0;
            end
            if (pwr_r == PWR_STOP && wake_evt) begin
                ctrl_r[CTRL_STOP_BIT] <= 1'b0;
            end
        end
    end

    // Prescaler, enable and wake mask registers
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            presc_r   <= PRESC_RST;
            irq_en_r  <= IRQ_EN_RST;
            wake_en_r <= WAKE_EN_RST;
        end else if (wr_en) begin
            if (paddr == PRESC_OFS)   presc_r   <= pwdata[7:0];
            if (paddr == IRQ_EN_OFS)  irq_en_r  <= pwdata[IRQ_W-1:0];
            if (paddr == WAKE_EN_OFS) wake_en_r <= pwdata[WAKE_W-1:0];
        end
    end

    // =========================================================
    // Clock source selection; reset picks the RC
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            src_r <= SRC_RC;
        end else begin
            case (src_r)
                SRC_RC: begin
                    if (ctrl_r[CTRL_SEL_EXT_BIT] && ctrl_r[CTRL_EXT_ON_BIT] && pwr_r == PWR_RUN) begin
                        src_r <= SRC_EXT;
                    end
                end
                SRC_EXT: begin
                    if (ext_fail || !ctrl_r[CTRL_SEL_EXT_BIT] || pwr_r == PWR_STOP) begin
                        src_r <= SRC_RC;
                    end
                end
                default: src_r <= SRC_RC;
            endcase
        end
    end

    // Power state: stop wins over sleep
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pwr_r <= PWR_RUN;
        end else begin
            case (pwr_r)
                PWR_RUN: begin
                    if (ctrl_r[CTRL_STOP_BIT]) pwr_r <= PWR_STOP;
                    else if (ctrl_r[CTRL_SLEEP_BIT]) pwr_r <= PWR_SLEEP;
                end
                PWR_SLEEP: begin
                    if (irq_pending || wake_evt) pwr_r <= PWR_RUN;
                end
                PWR_STOP: begin
                    if (wake_evt) pwr_r <= PWR_RUN;
                end
                default: pwr_r <= PWR_RUN;
            endcase
        end
    end

    // =========================================================
    // Bus prescaler dividers, one-cycle enables
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ahb_cnt_r  <= '0;
            apb_cnt_r  <= '0;
            ahb_clk_en <= 1'b0;
            apb_clk_en <= 1'b0;
        end else if (pwr_r == PWR_STOP) begin
            ahb_clk_en <= 1'b0;
            apb_clk_en <= 1'b0;
        end else begin
            ahb_clk_en <= (ahb_cnt_r == presc_r[3:0]);
            apb_clk_en <= (apb_cnt_r == presc_r[7:4]);
            ahb_cnt_r  <= (ahb_cnt_r >= presc_r[3:0]) ? '0 : ahb_cnt_r + 1'b1;
            apb_cnt_r  <= (apb_cnt_r >= presc_r[7:4]) ? '0 : apb_cnt_r + 1'b1;
        end
    end

    // Oscillator and gate outputs
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sys_clk_sel_ext         <= 1'b0;
            external_crystal_osc_en <= 1'b0;
            internal_fast_rc_en     <= 1'b1;
            pll_en                  <= 1'b0;
            cpu_clk_en              <= 1'b1;
            low_speed_keep_en       <= 1'b1;
        end else begin
            sys_clk_sel_ext         <= (src_r == SRC_EXT);
            external_crystal_osc_en <= ctrl_r[CTRL_EXT_ON_BIT] && pwr_r != PWR_STOP;
            internal_fast_rc_en     <= (pwr_r != PWR_STOP);
            pll_en                  <= ctrl_r[CTRL_PLL_ON_BIT] && pwr_r != PWR_STOP;
            cpu_clk_en              <= (pwr_r == PWR_RUN);
            low_speed_keep_en       <= 1'b1;
        end
    end

    // =========================================================
    // Interrupt status: sticky, set beats clear
    assign irq_set = {wake_evt && pwr_r == PWR_STOP, pll_fail, ext_fail};
    assign irq_clr = (wr_en && paddr == IRQ_CLR_OFS) ? pwdata[IRQ_W-1:0] : '0;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            irq_stat_r <= '0;
        end else begin
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((irq_stat_r & ~irq_clr) | irq_set) & irq_en_r);
        end
    end

    // =========================================================
    // Read data captured in setup phase
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            prdata <= '0;
        end else if (rd_en) begin
            case (paddr)
                CTRL_OFS:     prdata <= {27'h0, ctrl_r};
                PRESC_OFS:    prdata <= {24'h0, presc_r};
                STATE_OFS:    prdata <= {28'h0, pwr_r, src_r};
                IRQ_STAT_OFS: prdata <= {29'h0, irq_stat_r};
                IRQ_EN_OFS:   prdata <= {29'h0, irq_en_r};
                WAKE_EN_OFS:  prdata <= {10'h0, wake_en_r};
                default:      prdata <= '0;
            endcase
        end
    end

    // =========================================================
    // Checks: reset and clock source
    reset_rc_a: assert property (@(posedge core_clk)
        $fell(rst) |-> src_r == SRC_RC)
        else $error("source not rc after reset");
    rst_out_a: assert property (@(posedge core_clk)
        $fell(rst) |-> !sys_clk_sel_ext && internal_fast_rc_en && cpu_clk_en)
        else $error("gate outputs not at reset state");
    sel_ext_a: assert property (@(posedge core_clk) disable iff (rst)
        pwr_r == PWR_RUN && !ext_fail && ctrl_r[CTRL_SEL_EXT_BIT] && ctrl_r[CTRL_EXT_ON_BIT] |=> src_r == SRC_EXT)
        else $error("external source not taken");
    ext_on_a: assert property (@(posedge core_clk) disable iff (rst)
        ctrl_r[CTRL_EXT_ON_BIT] && pwr_r != PWR_STOP |=> external_crystal_osc_en)
        else $error("external oscillator not enabled");
    mon_only_ext_a: assert property (@(posedge core_clk) disable iff (rst)
        ext_fail |-> $past(src_r) == SRC_EXT)
        else $error("failure flagged without ext");
    fail_back_a: assert property (@(posedge core_clk) disable iff (rst)
        ext_fail |=> src_r == SRC_RC ##1 !sys_clk_sel_ext)
        else $error("no fallback on failure");
    sel_clr_a: assert property (@(posedge core_clk) disable iff (rst)
        ext_fail |=> !ctrl_r[CTRL_SEL_EXT_BIT])
        else $error("selection kept after failure");

    // Checks: interrupts and pll enable
    irq_gate_a: assert property (@(posedge core_clk) disable iff (rst)
        irq |-> |(irq_stat_r & $past(irq_en_r)))
        else $error("irq without enabled status");
    irq_raise_a: assert property (@(posedge core_clk) disable iff (rst)
        |(irq_stat_r & $past(irq_en_r)) |-> irq)
        else $error("enabled status without irq");
    fail_flag_a: assert property (@(posedge core_clk) disable iff (rst)
        ext_fail |=> irq_stat_r[IRQ_EXT_FAIL_BIT])
        else $error("ext failure not recorded");
    pll_flag_a: assert property (@(posedge core_clk) disable iff (rst)
        pll_fail |=> irq_stat_r[IRQ_PLL_FAIL_BIT])
        else $error("pll failure not recorded");
    pll_on_a: assert property (@(posedge core_clk) disable iff (rst)
        ctrl_r[CTRL_PLL_ON_BIT] && pwr_r != PWR_STOP |=> pll_en)
        else $error("pll not enabled");
    sticky_a: assert property (@(posedge core_clk) disable iff (rst)
        irq_stat_r[IRQ_EXT_FAIL_BIT] && !irq_clr[IRQ_EXT_FAIL_BIT] |=> irq_stat_r[IRQ_EXT_FAIL_BIT])
        else $error("failure flag lost");

    // Checks: power modes
    run_cpu_a: assert property (@(posedge core_clk) disable iff (rst)
        pwr_r == PWR_RUN |=> cpu_clk_en)
        else $error("cpu clock off in run");
    sleep_cpu_a: assert property (@(posedge core_clk) disable iff (rst)
        pwr_r == PWR_SLEEP |=> !cpu_clk_en)
        else $error("cpu clock on in sleep");
    sleep_keep_a: assert property (@(posedge core_clk) disable iff (rst)
        pwr_r == PWR_SLEEP && presc_r == 8'h00 && $stable(presc_r) |=> ahb_clk_en && apb_clk_en)
        else $error("bus clocks stopped in sleep");
    sleep_wake_a: assert property (@(posedge core_clk) disable iff (rst)
        pwr_r == PWR_SLEEP && (irq_pending || wake_evt) |=> pwr_r == PWR_RUN)
        else $error("no wake from sleep");
    stop_osc_a: assert property (@(posedge core_clk) disable iff (rst)
        pwr_r == PWR_STOP |=> !internal_fast_rc_en && !pll_en && !external_crystal_osc_en && !ahb_clk_en)
        else $error("clocks running in stop");
    stop_src_a: assert property (@(posedge core_clk) disable iff (rst)
        pwr_r == PWR_STOP |=> src_r == SRC_RC)
        else $error("external source kept in stop");
    stop_mon_a: assert property (@(posedge core_clk) disable iff (rst)
        pwr_r == PWR_STOP |=> !ext_fail && !pll_fail)
        else $error("monitor active in stop");
    stop_hold_a: assert property (@(posedge core_clk) disable iff (rst)
        pwr_r == PWR_STOP && !wake_evt |=> pwr_r == PWR_STOP)
        else $error("stop left without event");
    stop_wake_a: assert property (@(posedge core_clk) disable iff (rst)
        pwr_r == PWR_STOP && wake_evt |=> pwr_r == PWR_RUN)
        else $error("no wake from stop");
    wake_flag_a: assert property (@(posedge core_clk) disable iff (rst)
        pwr_r == PWR_STOP && wake_evt |=> irq_stat_r[IRQ_WAKE_BIT])
        else $error("stop wake not recorded");
    keep_ls_a: assert property (@(posedge core_clk) disable iff (rst)
        pwr_r == PWR_STOP |=> low_speed_keep_en)
        else $error("low speed clocks stopped");

    // Checks: prescalers
    ahb_pulse_a: assert property (@(posedge core_clk) disable iff (rst)
        ahb_clk_en && pwr_r != PWR_STOP |=> ahb_clk_en == ($past(presc_r[3:0]) == 4'h0))
        else $error("ahb enable spacing wrong");
    apb_pulse_a: assert property (@(posedge core_clk) disable iff (rst)
        apb_clk_en && pwr_r != PWR_STOP |=> apb_clk_en == ($past(presc_r[7:4]) == 4'h0))
        else $error("apb enable spacing wrong");

    // Main scenarios reached
    cov_fail_c:  cover property (@(posedge core_clk) disable iff (rst) src_r == SRC_EXT ##1 ext_fail);
    cov_sleep_c: cover property (@(posedge core_clk) disable iff (rst) pwr_r == PWR_SLEEP ##1 pwr_r == PWR_RUN);
    cov_stop_c:  cover property (@(posedge core_clk) disable iff (rst) pwr_r == PWR_STOP ##1 pwr_r == PWR_RUN);
    cov_pll_c:   cover property (@(posedge core_clk) disable iff (rst) pll_fail);
    cov_irq_c:   cover property (@(posedge core_clk) disable iff (rst) irq ##1 !irq);

endmodule

// ### rtl/clk_ctrl_pkg.sv
package clk_ctrl_pkg;

    // =========================================================
    // Register offsets (byte addresses)
    localparam logic [11:0] CTRL_OFS      = 12'h000;
    localparam logic [11:0] PRESC_OFS     = 12'h004;
    localparam logic [11:0] STATE_OFS     = 12'h008;
    localparam logic [11:0] IRQ_STAT_OFS  = 12'h00c;
    localparam logic [11:0] IRQ_CLR_OFS   = 12'h010;
    localparam logic [11:0] IRQ_EN_OFS    = 12'h014;
    localparam logic [11:0] WAKE_EN_OFS   = 12'h018;

    // =========================================================
    // Control register fields
    localparam int CTRL_EXT_ON_BIT  = 0;
    localparam int CTRL_SEL_EXT_BIT = 1;
    localparam int CTRL_PLL_ON_BIT  = 2;
    localparam int CTRL_SLEEP_BIT   = 3;
    localparam int CTRL_STOP_BIT    = 4;

    // Interrupt status fields
    localparam int IRQ_EXT_FAIL_BIT = 0;
    localparam int IRQ_PLL_FAIL_BIT = 1;
    localparam int IRQ_WAKE_BIT     = 2;
    localparam int IRQ_W            = 3;

    // Prescaler fields: ahb divisor [3:0], apb divisor [7:4], value+1 divides
    localparam int PRESC_W          = 4;

    // =========================================================
    // Reset values
    localparam logic [4:0]  CTRL_RST     = 5'h00;
    localparam logic [7:0]  PRESC_RST    = 8'h00;
    localparam logic [IRQ_W-1:0] IRQ_EN_RST = 3'h0;
    localparam int          WAKE_W       = 22;
    localparam logic [21:0] WAKE_EN_RST  = 22'h3fffff;

    // =========================================================
    // Timing: clock monitor window
    localparam int CORE_HZ          = 40_000_000;
    localparam int MON_WIN_NS       = 1000;
    localparam int MON_WIN_CYC      = (MON_WIN_NS * (CORE_HZ / 1_000_000)) / 1000;
    localparam int MON_CNT_W        = 8;
    localparam logic [MON_CNT_W-1:0] MON_WIN_LAST = 8'(MON_WIN_CYC - 1);

    // =========================================================
    // Clock source and power states
    typedef enum logic [1:0] {
        SRC_RC,
        SRC_EXT
    } clk_src_type;

    typedef enum logic [1:0] {
        PWR_RUN,
        PWR_SLEEP,
        PWR_STOP
    } pwr_state_type;

endpackage

// ### rtl/clk_edge_monitor.sv
`timescale 1ns/1ps
// Watches an oscillator activity toggle; flags a window with no change
module clk_edge_monitor
    import clk_ctrl_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic enable,
    input  wire logic osc_toggle,
    output logic      failed
);

    logic                 prev_r;
    logic                 seen_r;
    logic [MON_CNT_W-1:0] cnt_r;

    // =========================================================
    // Window counter and activity tracking
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            prev_r <= 1'b0;
            seen_r <= 1'b0;
            cnt_r  <= '0;
            failed <= 1'b0;
        end else begin
            prev_r <= osc_toggle;
            failed <= 1'b0;
            if (!enable) begin
                cnt_r  <= '0;
                seen_r <= 1'b0;
            end else if (cnt_r == MON_WIN_LAST) begin
                cnt_r  <= '0;
                seen_r <= 1'b0;
                failed <= !(seen_r || (osc_toggle != prev_r));
            end else begin
                cnt_r  <= cnt_r + 1'b1;
                seen_r <= seen_r || (osc_toggle != prev_r);
            end
        end
    end

endmodule

// ### verification/testbench.sv
`timescale 1ns/1ps
module testbench
    import clk_ctrl_pkg::*;
;
    // ==========================================
    // Design signals
    logic              core_clk;
    logic              rst;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [11:0]       paddr;
    logic [31:0]       pwdata;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic              ext_osc_toggle;
    logic              pll_ref_toggle;
    logic              irq_pending;
    logic [WAKE_W-1:0] event_lines;
    logic              sys_clk_sel_ext;
    logic              ext_en;
    logic              rc_en;
    logic              pll_en;
    logic              cpu_clk_en;
    logic              ahb_clk_en;
    logic              apb_clk_en;
    logic              keep_en;
    logic              irq;
    logic              ext_run;
    logic              pll_run;
    logic              last_err;
    int                err_count;
    int                n_checks;

    clk_ctrl i_dut (
        .core_clk                (core_clk),
        .rst                     (rst),
        .psel                    (psel),
        .penable                 (penable),
        .pwrite                  (pwrite),
        .paddr                   (paddr),
        .pwdata                  (pwdata),
        .prdata                  (prdata),
        .pready                  (pready),
        .pslverr                 (pslverr),
        .ext_osc_toggle          (ext_osc_toggle),
        .pll_ref_toggle          (pll_ref_toggle),
        .irq_pending             (irq_pending),
        .event_lines             (event_lines),
        .sys_clk_sel_ext         (sys_clk_sel_ext),
        .external_crystal_osc_en (ext_en),
        .internal_fast_rc_en     (rc_en),
        .pll_en                  (pll_en),
        .cpu_clk_en              (cpu_clk_en),
        .ahb_clk_en              (ahb_clk_en),
        .apb_clk_en              (apb_clk_en),
        .low_speed_keep_en       (keep_en),
        .irq                     (irq)
    );

    // ==========================================
    // Clock and oscillator activity
    always #12.5 core_clk = ~core_clk;

    // Toggles stand in for running oscillators
    always @(posedge core_clk) begin
        if (ext_run) ext_osc_toggle <= ~ext_osc_toggle;
        if (pll_run) pll_ref_toggle <= ~pll_ref_toggle;
    end

    // ==========================================
    // Shared tasks
    task automatic complete_run();
        $display("checks=%0d errors=%0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer; holds the request until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge core_clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        q = prdata;
        last_err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task automatic wait_cpu();
        int n;
        n = 0;
        while (cpu_clk_en !== 1'b1 && n < 20) begin @(posedge core_clk); n++; end
    endtask

    // Counts enable pulses over a number of edges
    task automatic count_en(input int n, output int na, output int np);
        na = 0;
        np = 0;
        repeat (n) begin
            @(posedge core_clk);
            na += int'(ahb_clk_en === 1'b1);
            np += int'(apb_clk_en === 1'b1);
        end
    endtask

    // ==========================================
    // Scenarios
    task automatic t_reset();
        chk(32'(sys_clk_sel_ext), 32'h0);
        chk(32'(rc_en), 32'h1);
        chk(32'(cpu_clk_en), 32'h1);
        chk(32'(irq), 32'h0);
        rd_chk(STATE_OFS, 32'h0);
        rd_chk(CTRL_OFS, 32'h0);
        rd_chk(IRQ_EN_OFS, 32'h0);
        rd_chk(WAKE_EN_OFS, 32'h003fffff);
        rd_chk(12'h020, 32'h0);
        chk(32'(last_err), 32'h1);
    endtask

    // External source selected, then lost, with interrupt on or off
    task automatic t_fail(input logic en);
        ext_run <= 1'b1;
        wr(IRQ_EN_OFS, {31'h0, en});
        wr(CTRL_OFS, 32'h3);
        cycles(60);
        chk(32'(sys_clk_sel_ext), 32'h1);
        chk(32'(ext_en), 32'h1);
        rd_chk(STATE_OFS, 32'h1);
        ext_run <= 1'b0;
        cycles(100);
        chk(32'(sys_clk_sel_ext), 32'h0);
        rd_chk(STATE_OFS, 32'h0);
        rd_chk(IRQ_STAT_OFS, 32'h1);
        chk(32'(irq), 32'(en));
        cycles(30);
        chk(32'(irq), 32'(en));
        wr(IRQ_CLR_OFS, 32'h1);
        cycles(2);
        chk(32'(irq), 32'h0);
        rd_chk(IRQ_STAT_OFS, 32'h0);
        wr(CTRL_OFS, 32'h0);
    endtask

    task automatic t_pll();
        wr(IRQ_EN_OFS, 32'h2);
        pll_run <= 1'b1;
        wr(CTRL_OFS, 32'h4);
        cycles(60);
        rd_chk(IRQ_STAT_OFS, 32'h0);
        chk(32'(pll_en), 32'h1);
        pll_run <= 1'b0;
        cycles(100);
        rd_chk(IRQ_STAT_OFS, 32'h2);
        chk(32'(irq), 32'h1);
        wr(CTRL_OFS, 32'h0);
        wr(IRQ_CLR_OFS, 32'h2);
        cycles(2);
        chk(32'(irq), 32'h0);
    endtask

    task automatic t_presc();
        int na;
        int np;
        wr(PRESC_OFS, 32'h12);
        cycles(8);
        count_en(60, na, np);
        chk(32'(na), 32'd20);
        chk(32'(np), 32'd30);
        wr(PRESC_OFS, 32'h0);
    endtask

    task automatic t_sleep();
        int na;
        int np;
        wr(CTRL_OFS, 32'h8);
        cycles(3);
        chk(32'(cpu_clk_en), 32'h0);
        rd_chk(STATE_OFS, 32'h4);
        count_en(10, na, np);
        chk(32'(na + np), 32'd20);
        irq_pending <= 1'b1;
        wait_cpu();
        chk(32'(cpu_clk_en), 32'h1);
        irq_pending <= 1'b0;
        rd_chk(CTRL_OFS, 32'h0);
    endtask

    // Stop entry, then an event on line i with the given wake enables
    task automatic t_stop(input int i, input logic [21:0] men);
        int na;
        int np;
        wr(WAKE_EN_OFS, {10'h0, men});
        wr(CTRL_OFS, 32'h11);
        cycles(3);
        chk(32'(cpu_clk_en | pll_en | rc_en | ext_en), 32'h0);
        chk(32'(keep_en), 32'h1);
        count_en(10, na, np);
        chk(32'(na + np), 32'h0);
        event_lines <= 22'(1) << i;
        cycles(20);
        chk(32'(cpu_clk_en), 32'(men[i]));
        if (men[i] !== 1'b1) wr(WAKE_EN_OFS, 32'h003fffff);
        wait_cpu();
        chk(32'(cpu_clk_en & rc_en), 32'h1);
        chk(32'(ext_en), 32'h1);
        event_lines <= '0;
        rd_chk(IRQ_STAT_OFS, 32'h4);
        wr(IRQ_CLR_OFS, 32'h4);
    endtask

    // Reset in mid-run while the external source is selected
    task automatic t_rerun();
        ext_run <= 1'b1;
        wr(CTRL_OFS, 32'h3);
        cycles(5);
        chk(32'(sys_clk_sel_ext), 32'h1);
        rst <= 1'b1;
        cycles(3);
        chk(32'(sys_clk_sel_ext | ext_en), 32'h0);
        rst <= 1'b0;
        cycles(1);
        chk(32'(rc_en & cpu_clk_en), 32'h1);
        rd_chk(STATE_OFS, 32'h0);
        rd_chk(CTRL_OFS, 32'h0);
        ext_run <= 1'b0;
    endtask

    // ==========================================
    // Main sequence
    initial begin
        core_clk = 1'b0;
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        ext_osc_toggle = 1'b0;
        pll_ref_toggle = 1'b0;
        irq_pending = 1'b0;
        event_lines = '0;
        ext_run = 1'b0;
        pll_run = 1'b0;
        last_err = 1'b0;
        err_count = 0;
        n_checks = 0;
        cycles(16);
        rst <= 1'b0;
        cycles(1);
        t_reset();
        t_fail(1'b1);
        t_fail(1'b0);
        t_pll();
        t_presc();
        t_sleep();
        t_stop(0, 22'h3fffff);
        t_stop(21, 22'h3fffff);
        t_stop(7, 22'h3fff7f);
        t_rerun();
        complete_run();
    end

    // Watchdog against a hung wait
    initial begin
        repeat (30000) @(posedge core_clk);
        err_count++;
        complete_run();
    end
endmodule
